// >>> hw/srm_decoder.v
// Operation
// - alias selectors sit in groups 10001 through 10011
// - listed reserved selector values are unpredictable
// - plain selectors use current security bank
// - secure state alias reaches non-secure copy
// - non-secure alias access reads zero, ignores writes
// - conditional raise selector reads base priority
// - exception number only privileged, bit0 set
// - flags when bit2 clear, ge with dsp
// - execution state fields read as zero
// - group 00001 stack pointers and limits
// - alias stack group needs security, secure, privilege
// - mask group fields, main extension needed for sub 001 to 011
// - control width depends on fp and security
// - alias mask group returns non-secure copies
// - alias current stack pointer at sub 000
// - invalid read selector picks one fixed outcome
// - write mask field checked against selector
// - write source index 13 or 15 unpredictable
// - bad write combination picks one fixed outcome
// - write status views and main stack selector
// - read destination 13 or 15 unpredictable
`timescale 1ns/1ps
`include "srm_map.vh"
module srm_decoder #(
    parameter [1:0] BAD_OUTCOME = `SRM_OUT_UNDEF
) (
    input  wire        clk_i,
    input  wire        rstn_i,
    input  wire        rd_req_i,
    input  wire        wr_req_i,
    input  wire [7:0]  special_reg_selector_i,
    input  wire [3:0]  dest_gpr_index_i,
    input  wire [3:0]  source_gpr_index_i,
    input  wire [1:0]  wr_mask_i,
    input  wire        privileged_i,
    input  wire        secure_i,
    input  wire        thread_uses_nonsecure_process_stack_ptr_i,
    input  wire        have_main_ext_i,
    input  wire        have_dsp_ext_i,
    input  wire        have_fp_ext_i,
    input  wire        have_sec_ext_i,
    input  wire [8:0]  active_exception_i,
    input  wire        handler_mode_i,
    input  wire [4:0]  cond_flags_i,
    input  wire [3:0]  ge_flags_i,
    input  wire [31:0] main_stack_ptr_i,
    input  wire [31:0] process_stack_ptr_i,
    input  wire [31:0] nonsecure_main_stack_ptr_i,
    input  wire [31:0] nonsecure_process_stack_ptr_i,
    input  wire [28:0] secure_main_stack_limit_i,
    input  wire [28:0] secure_process_stack_limit_i,
    input  wire [28:0] nonsecure_main_stack_limit_i,
    input  wire [28:0] nonsecure_process_stack_limit_i,
    input  wire        irq_priority_mask_i,
    input  wire [7:0]  base_priority_i,
    input  wire        fault_mask_a_i,
    input  wire [3:0]  control_word_i,
    input  wire        nonsecure_irq_priority_mask_i,
    input  wire [7:0]  nonsecure_base_priority_i,
    input  wire        nonsecure_fault_mask_i,
    input  wire [2:0]  nonsecure_control_word_i,
    output reg  [31:0] rd_data_o,
    output reg         rd_valid_o,
    output reg         rd_unpred_o,
    output reg  [1:0]  rd_outcome_o,
    output reg         wr_unpred_o,
    output reg  [1:0]  wr_outcome_o,
    output reg         wr_ignore_o,
    output reg         wr_valid_o
);
    wire [4:0] grp = special_reg_selector_i[7:3];
    wire [2:0] sub = special_reg_selector_i[2:0];
    wire       alias_sel = special_reg_selector_i[7];

    reg [31:0] next_data;
    reg        next_unpred;
    reg        next_wunpred;

    wire       rd_bad   = rd_req_i & next_unpred;
    wire       wr_bad   = wr_req_i & next_wunpred;
    wire       ns_alias = wr_req_i & alias_sel & ~secure_i;

    // read datapath; start from zero so suppressed fields read zero
    always @*
    begin
        next_data   = `SRM_ZERO32;
        next_unpred = 1'b0;
        if (dest_gpr_index_i == `SRM_GPR_SP || dest_gpr_index_i == `SRM_GPR_PC)
            next_unpred = 1'b1;
        if (grp == `SRM_GRP_STATUS)
        begin
            if (special_reg_selector_i == `SRM_SEL_RESERVED)
                next_unpred = 1'b1;
            if (privileged_i && sub[0])
                next_data[8:0] = active_exception_i;
            if (sub[1])
            begin
                next_data[26:24] = 3'h0;
                next_data[15:10] = 6'h00;
            end
            if (!sub[2])
            begin
                next_data[31:27] = cond_flags_i;
                if (have_dsp_ext_i)
                    next_data[19:16] = ge_flags_i;
            end
        end
        else if (grp == `SRM_GRP_SP)
        begin
            // banked by current security state
            if (privileged_i)
            begin
                if (sub == `SRM_SUB_0)
                    next_data = main_stack_ptr_i;
                else if (sub == `SRM_SUB_1)
                    next_data = process_stack_ptr_i;
                else if (sub == `SRM_SUB_2 || sub == `SRM_SUB_3)
                begin
                    if (secure_i)
                        next_data = {(sub[0] ? secure_process_stack_limit_i
                                             : secure_main_stack_limit_i),
                                     `SRM_LIM_PAD};
                    else if (have_main_ext_i)
                        next_data = {(sub[0] ? nonsecure_process_stack_limit_i
                                             : nonsecure_main_stack_limit_i),
                                     `SRM_LIM_PAD};
                    else
                        next_unpred = 1'b1;
                end
                else
                    next_unpred = 1'b1;
            end
            else if (sub[2])
                next_unpred = 1'b1;
        end
        else if (grp == `SRM_GRP_PRI)
        begin
            if (sub == `SRM_SUB_0)
            begin
                if (privileged_i)
                    next_data[0] = irq_priority_mask_i;
            end
            else if (sub == `SRM_SUB_1 || sub == `SRM_SUB_2 || sub == `SRM_SUB_3)
            begin
                if (!have_main_ext_i || !privileged_i)
                    next_unpred = 1'b1;
                else if (sub == `SRM_SUB_3)
                    next_data[0] = fault_mask_a_i;
                else
                    next_data[7:0] = base_priority_i;
            end
            else if (sub == `SRM_SUB_4)
            begin
                if (have_fp_ext_i && secure_i)
                    next_data[3:0] = control_word_i;
                else if (have_fp_ext_i)
                    next_data[2:0] = control_word_i[2:0];
                else
                    next_data[1:0] = control_word_i[1:0];
            end
            else
                next_unpred = 1'b1;
        end
        else if (grp == `SRM_GRP_NS_SP)
        begin
            if (!have_sec_ext_i)
                next_unpred = 1'b1;
            else if (sub[2])
                next_unpred = 1'b1;
            else if (privileged_i && secure_i)
            begin
                // non-secure copy from secure state
                if (sub == `SRM_SUB_0)
                    next_data = nonsecure_main_stack_ptr_i;
                else if (sub == `SRM_SUB_1)
                    next_data = nonsecure_process_stack_ptr_i;
                else if (have_main_ext_i)
                    next_data = {(sub[0] ? nonsecure_process_stack_limit_i
                                         : nonsecure_main_stack_limit_i),
                                 `SRM_LIM_PAD};
                else
                    next_unpred = 1'b1;
            end
            // non-secure state leaves the zero result
        end
        else if (grp == `SRM_GRP_NS_PRI)
        begin
            if (!have_sec_ext_i)
                next_unpred = 1'b1;
            else if (sub == `SRM_SUB_2 || sub[2:1] == 2'h3 || sub == 3'h5)
                next_unpred = 1'b1;
            else if (secure_i)
            begin
                if (sub == `SRM_SUB_4)
                begin
                    if (have_fp_ext_i)
                        next_data[2:0] = nonsecure_control_word_i;
                    else
                        next_data[1:0] = nonsecure_control_word_i[1:0];
                end
                else if (privileged_i)
                begin
                    if (sub == `SRM_SUB_0)
                        next_data[0] = nonsecure_irq_priority_mask_i;
                    else if (sub == `SRM_SUB_1)
                        next_data[7:0] = nonsecure_base_priority_i;
                    else
                        next_data[0] = nonsecure_fault_mask_i;
                end
            end
        end
        else if (grp == `SRM_GRP_NS_CUR_SP)
        begin
            if (!have_sec_ext_i || sub != `SRM_SUB_0)
                next_unpred = 1'b1;
            else if (secure_i)
                next_data = (!handler_mode_i && thread_uses_nonsecure_process_stack_ptr_i)
                            ? nonsecure_process_stack_ptr_i
                            : nonsecure_main_stack_ptr_i;
        end
        else
            next_unpred = 1'b1;
    end

    // write-side decode checks only; the write datapath lives elsewhere
    always @*
    begin
        next_wunpred = 1'b0;
        if (have_main_ext_i)
        begin
            if (wr_mask_i == `SRM_MASK_NONE ||
                (wr_mask_i != `SRM_MASK_FLAGS &&
                 special_reg_selector_i > `SRM_SEL_MAX_FLAGS))
                next_wunpred = 1'b1;
        end
        else if (wr_mask_i != `SRM_MASK_FLAGS)
            next_wunpred = 1'b1;
        if (source_gpr_index_i == `SRM_GPR_SP || source_gpr_index_i == `SRM_GPR_PC)
            next_wunpred = 1'b1;
        if (grp == `SRM_GRP_STATUS && special_reg_selector_i == `SRM_SEL_RESERVED)
            next_wunpred = 1'b1;
    end

    // outputs registered: one cycle after the request
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rd_valid_o   <= 1'b0;
            rd_unpred_o  <= 1'b0;
        end
        else
        begin
            rd_valid_o   <= rd_req_i;
            rd_unpred_o  <= rd_bad;
        end
    end

    // unknown outcome modelled as zero to avoid leaking data
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rd_data_o    <= `SRM_ZERO32;
            rd_outcome_o <= `SRM_OUT_NOP;
        end
        else
        begin
            rd_data_o    <= (rd_req_i && !next_unpred) ? next_data : `SRM_ZERO32;
            rd_outcome_o <= rd_bad ? BAD_OUTCOME : `SRM_OUT_NOP;
        end
    end

    // write decode verdict; the register update itself happens downstream
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wr_valid_o   <= 1'b0;
            wr_unpred_o  <= 1'b0;
        end
        else
        begin
            wr_valid_o   <= wr_req_i & ~next_wunpred;
            wr_unpred_o  <= wr_bad;
        end
    end

    // ignore flag only; the write path must drop the data itself
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wr_outcome_o <= `SRM_OUT_NOP;
            wr_ignore_o  <= 1'b0;
        end
        else
        begin
            wr_outcome_o <= wr_bad ? BAD_OUTCOME : `SRM_OUT_NOP;
            wr_ignore_o  <= ns_alias;
        end
    end
endmodule

// >>> hw/srm_map.vh
`ifndef SRM_MAP_VH
`define SRM_MAP_VH
`define SRM_GRP_STATUS     5'h00
`define SRM_GRP_SP         5'h01
`define SRM_GRP_PRI        5'h02
`define SRM_GRP_NS_SP      5'h11
`define SRM_GRP_NS_PRI     5'h12
`define SRM_GRP_NS_CUR_SP  5'h13
`define SRM_SUB_0          3'h0
`define SRM_SUB_1          3'h1
`define SRM_SUB_2          3'h2
`define SRM_SUB_3          3'h3
`define SRM_SUB_4          3'h4
`define SRM_SEL_RESERVED   8'h04
`define SRM_SEL_MAX_FLAGS  8'h03
`define SRM_MASK_NONE      2'h0
`define SRM_MASK_FLAGS     2'h2
`define SRM_GPR_SP         4'hD
`define SRM_GPR_PC         4'hF
`define SRM_ZERO32         32'h00000000
`define SRM_LIM_PAD        3'h0
`define SRM_OUT_NOP        2'h0
`define SRM_OUT_UNDEF      2'h1
`define SRM_OUT_UNKNOWN    2'h2
`endif

// >>> verification/srm_decoder_checker.sv
`timescale 1ns/1ps
module srm_decoder_checker #(
    parameter [1:0] BAD_OUTCOME = 2'h1
) (
    input wire        clk_i,
    input wire        rstn_i,
    input wire        rd_req_i,
    input wire        wr_req_i,
    input wire [7:0]  special_reg_selector_i,
    input wire [3:0]  dest_gpr_index_i,
    input wire [3:0]  source_gpr_index_i,
    input wire [1:0]  wr_mask_i,
    input wire        have_main_ext_i,
    input wire        secure_i,
    input wire [3:0]  control_word_i,
    input wire [31:0] rd_data_o,
    input wire        rd_unpred_o,
    input wire [1:0]  rd_outcome_o,
    input wire        wr_unpred_o
);
    wire [7:0] s = special_reg_selector_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_res; rd_req_i && s == 8'h04 |=> rd_unpred_o; endproperty
    a_res: assert property (p_res) else $error("reserved selector not flagged");
    property p_ns; rd_req_i && s[7] && !secure_i |=> rd_data_o == 32'h0; endproperty
    a_ns: assert property (p_ns) else $error("alias read leaked data");
    property p_ctl; rd_req_i && s == 8'h14 && dest_gpr_index_i < 4'hD
        |=> !rd_unpred_o && rd_data_o[1:0] == $past(control_word_i[1:0]) ##0 rd_data_o[31:4] == 28'h0;
    endproperty
    a_ctl: assert property (p_ctl) else $error("control read wrong");
    property p_dst; rd_req_i && dest_gpr_index_i[3:2] == 2'h3 && dest_gpr_index_i[0]
        |=> rd_unpred_o && rd_data_o == 32'h0; endproperty
    a_dst: assert property (p_dst) else $error("bad destination not flagged");
    property p_src; wr_req_i && source_gpr_index_i[3:2] == 2'h3 && source_gpr_index_i[0]
        |=> wr_unpred_o; endproperty
    a_src: assert property (p_src) else $error("bad source not flagged");
    property p_msk; wr_req_i && wr_mask_i != 2'h2 && (!have_main_ext_i || wr_mask_i == 2'h0
        || s > 8'h03) |=> wr_unpred_o; endproperty
    a_msk: assert property (p_msk) else $error("bad mask not flagged");
    property p_ok; wr_req_i && wr_mask_i == 2'h2 && s < 8'h04 && source_gpr_index_i < 4'hD
        |=> !wr_unpred_o; endproperty
    a_ok: assert property (p_ok) else $error("legal write flagged");
    property p_oc; rd_unpred_o |-> rd_outcome_o == BAD_OUTCOME; endproperty
    a_oc: assert property (p_oc) else $error("outcome code wrong");
endmodule
bind srm_decoder srm_decoder_checker #(.BAD_OUTCOME(BAD_OUTCOME)) u_chk (.*);

// >>> verification/srm_gpr_model.sv
`timescale 1ns/1ps
module srm_gpr_model (
    input  wire        clk_i,
    input  wire        wb_en_i,
    input  wire [31:0] wb_data_i,
    output reg  [31:0] wb_q_o
);
    // whole word replaced, never merged, so stale bits cannot survive
    always @(posedge clk_i)
    begin
        if (wb_en_i)
            wb_q_o <= wb_data_i;
    end
endmodule

// >>> verification/special_register_move_access_tb_top.sv
`timescale 1ns/1ps
`include "srm_map.vh"
module special_register_move_access_tb_top;
    localparam [199:0] VSEL = 200'h98949391908B8A898814131211100B0A090807060503020100;
    reg         clk_i = 1'b0;
    reg         rstn_i = 1'b0;
    reg         rd_req_i = 1'b0;
    reg         wr_req_i = 1'b0;
    reg  [7:0]  sel = 8'h00;
    reg  [3:0]  dst = 4'h0;
    reg  [3:0]  src = 4'h0;
    reg  [1:0]  msk = 2'h0;
    reg  [7:0]  cf = 8'h00;
    reg  [31:0] r [0:7];
    reg  [31:0] t;
    integer     seed = 75743;
    integer     i;
    integer     bad_count = 0;
    integer     comparisons = 0;
    wire [31:0] rd_data;
    wire [31:0] wb_q;
    wire        rd_valid;
    wire        rd_unpred;
    wire [1:0]  rd_oc;
    wire        wr_unp;
    wire [1:0]  wr_oc;
    wire        wr_ign;
    wire        wr_val;
    initial forever #12.5 clk_i = ~clk_i;
    srm_decoder uut (.clk_i(clk_i), .rstn_i(rstn_i), .rd_req_i(rd_req_i), .wr_req_i(wr_req_i),
        .special_reg_selector_i(sel), .dest_gpr_index_i(dst), .source_gpr_index_i(src),
        .wr_mask_i(msk), .privileged_i(cf[0]), .secure_i(cf[1]), .thread_uses_nonsecure_process_stack_ptr_i(cf[2]),
        .have_main_ext_i(cf[3]), .have_dsp_ext_i(cf[4]), .have_fp_ext_i(cf[5]),
        .have_sec_ext_i(cf[6]), .handler_mode_i(cf[7]), .active_exception_i(r[4][31:23]),
        .cond_flags_i(r[5][31:27]), .ge_flags_i(r[6][31:28]), .main_stack_ptr_i(r[0]),
        .process_stack_ptr_i(r[1]), .nonsecure_main_stack_ptr_i(r[2]),
        .nonsecure_process_stack_ptr_i(r[3]), .secure_main_stack_limit_i(r[4][28:0]),
        .secure_process_stack_limit_i(r[5][28:0]), .nonsecure_main_stack_limit_i(r[6][28:0]),
        .nonsecure_process_stack_limit_i(r[7][28:0]), .irq_priority_mask_i(r[7][31]),
        .base_priority_i(r[7][30:23]), .fault_mask_a_i(r[0][0]), .control_word_i(r[1][3:0]),
        .nonsecure_irq_priority_mask_i(r[2][0]), .nonsecure_base_priority_i(r[3][7:0]),
        .nonsecure_fault_mask_i(r[2][1]), .nonsecure_control_word_i(r[3][10:8]),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid), .rd_unpred_o(rd_unpred), .rd_outcome_o(rd_oc),
        .wr_unpred_o(wr_unp), .wr_outcome_o(wr_oc), .wr_ignore_o(wr_ign), .wr_valid_o(wr_val));
    srm_gpr_model gpr (.clk_i(clk_i), .wb_en_i(rd_valid & ~rd_unpred), .wb_data_i(rd_data),
        .wb_q_o(wb_q));
    function [32:0] mdl(input [7:0] s);
        reg [31:0] d;
        reg        u;
        begin
            {u, d} = 33'h0;
            case (s[7:3])
            5'h00: d = {s[2] ? 5'h0 : r[5][31:27], 7'h0, s[2] | !cf[4] ? 4'h0 : r[6][31:28],
                        7'h0, cf[0] && s[0] ? r[4][31:23] : 9'h0};
            5'h01: if (s[2]) u = 1'b1;
                else if (cf[0] && !s[1]) d = s[0] ? r[1] : r[0];
                else if (cf[0] && cf[1]) d = {s[0] ? r[5][28:0] : r[4][28:0], 3'h0};
                else if (cf[0] && cf[3]) d = {s[0] ? r[7][28:0] : r[6][28:0], 3'h0};
                else u = cf[0];
            5'h02: case (s[2:0])
                3'h0: d[0] = cf[0] & r[7][31];
                3'h1, 3'h2: if (cf[3] && cf[0]) d[7:0] = r[7][30:23]; else u = 1'b1;
                3'h3: if (cf[3] && cf[0]) d[0] = r[0][0]; else u = 1'b1;
                3'h4: d[3:0] = cf[5] ? r[1][3:0] & {cf[1], 3'h7} : {2'h0, r[1][1:0]};
                default: u = 1'b1;
                endcase
            5'h11: if (!cf[6] || s[2]) u = 1'b1;
                else if (cf[0] && cf[1] && !s[1]) d = s[0] ? r[3] : r[2];
                else if (cf[0] && cf[1] && cf[3]) d = {s[0] ? r[7][28:0] : r[6][28:0], 3'h0};
                else if (cf[0] && cf[1]) u = 1'b1;
            5'h12: if (!cf[6] || s[2:0] == 3'h2 || s[2:0] > 3'h4) u = 1'b1;
                else if (cf[1] && s[2]) d[2:0] = r[3][10:8] & {cf[5], 2'h3};
                else if (cf[1] && cf[0]) d = s[0] ? (s[1] ? r[2][1] : r[3][7:0]) : r[2][0];
            5'h13: if (!cf[6] || s[2:0] != 3'h0) u = 1'b1;
                else if (cf[1]) d = (!cf[7] && cf[2]) ? r[3] : r[2];
            default: u = 1'b1;
            endcase
            mdl = (u || s == 8'h04 || dst == 4'hD || dst == 4'hF) ? {1'b1, 32'h0} : {1'b0, d};
        end
    endfunction
    function wmdl(input [7:0] s);
        begin
            wmdl = (cf[3] ? (msk == 2'h0 || (msk != 2'h2 && s > 8'h03)) : msk != 2'h2)
                   || src == 4'hD || src == 4'hF || s == 8'h04;
        end
    endfunction
    task chk(input [8*10-1:0] nm, input [32:0] seen, input [32:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp)
            begin
                bad_count = bad_count + 1;
                $display("mismatch %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task op(input full);
        reg [32:0] e;
        reg        w;
        reg        wq;
        begin
            @(posedge clk_i);
            for (i = 0; i < 8; i = i + 1)
                r[i] <= $random(seed);
            t = $random(seed);
            cf <= full ? (t[7:0] | 8'h7B) : t[7:0];
            sel <= full ? t[15:8] : VSEL[8 * (t[20:16] % 25) +: 8];
            {dst, src, msk} <= t[30:21];
            rd_req_i <= 1'b1;
            wr_req_i <= t[31];
            @(negedge clk_i);
            e = mdl(sel);
            w = wmdl(sel);
            wq = wr_req_i;
            @(posedge clk_i);
            rd_req_i <= 1'b0;
            wr_req_i <= 1'b0;
            @(negedge clk_i);
            chk("valid", rd_valid, 1);
            chk("unpred", rd_unpred, e[32]);
            chk("outcome", rd_oc, e[32] ? `SRM_OUT_UNDEF : `SRM_OUT_NOP);
            chk("data", rd_data, e[31:0]);
            chk("data", rd_data, e[31:0]);
            chk("wvalid", wr_val, wq & ~w);
            chk("wunpred", wr_unp, wq & w);
            chk("woutcome", wr_oc, (wq & w) ? `SRM_OUT_UNDEF : `SRM_OUT_NOP);
            chk("wignore", wr_ign, wq & sel[7] & ~cf[1]);
            @(negedge clk_i);
            if (!e[32])
                chk("wb", wb_q, e[31:0]);
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial
    begin
        for (i = 0; i < 8; i = i + 1)
            r[i] = 32'h0;
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (600) op(1'b0);
        $display("test table selectors done");
        repeat (600) op(1'b1);
        $display("test random selectors done");
        tally_and_finish;
    end
    initial
    begin
        #(25 * 6000);
        bad_count = bad_count + 1;
        tally_and_finish;
    end
endmodule
